// ---- src/dcbb_consts.svh ----
// Constants for the buck/boost supply control block
//
// Contract
// - Supply module on in normal, stop, restart only
// - Buck PWM in normal, restart, stop after transition
// - Entering stop forces buck to PFM automatically
// - PFM switching is asynchronous, no imposed frequency
// - PWM duty may reach full on-time
// - Soft-start at power-up, sleep/fail-safe to restart
// - Soft-start begins at minimum duty, held
// - Duty stepped up and held until target
// - Target reached hands duty to regulation
// - Status flags switch-node faults and output window
// - Status flags never change mode or configuration
// - Boost enable honoured only in normal and stop
// - Voltage-select picks output and threshold pair
// - Boost on below threshold, off above hysteresis
// - Active flag set on start, write-clear only above threshold
// - Boost only ever uses fixed-frequency PWM
// - Stop overcurrent moves buck to PWM, event, flag
// - Stop command returns PFM; clearing auto bit disables auto
`ifndef DCBB_CONSTS_SVH
`define DCBB_CONSTS_SVH

// Register indices
`define DCBB_ADDR_CTRL      4'h0
`define DCBB_ADDR_STAT      4'h1
`define DCBB_ADDR_WAKE      4'h2
`define DCBB_ADDR_STATE     4'h3

// Control register fields
`define DCBB_CTRL_BOOST_EN  0
`define DCBB_CTRL_BOOST_V   1
`define DCBB_CTRL_PWM_AUTO  2
`define DCBB_CTRL_PWM_BY_WK 3
`define DCBB_CTRL_RESET     8'h04

// Status register fields (write one to clear)
`define DCBB_STAT_SW_OPEN   0
`define DCBB_STAT_SW_SHORT  1
`define DCBB_STAT_OUT_WIN   2

// Soft-start shaping
`define DCBB_DUTY_MIN       8'h08
`define DCBB_DUTY_STEP      8'h08
`define DCBB_DUTY_FULL      8'hFF
`define DCBB_HOLD_PERIODS   4'h8

// Switching period: 2000 ns at 5 ns clock
`define DCBB_SW_PERIOD_NS   2000
`define DCBB_CLK_PERIOD_NS  5
`define DCBB_SW_CYCLES      (`DCBB_SW_PERIOD_NS / `DCBB_CLK_PERIOD_NS)

`endif

// ---- src/dcbb_pkg.sv ----
// Types for the buck/boost supply control block
package dcbb_pkg;

    typedef enum logic [2:0] {
        DCBB_MODE_NORMAL  = 3'h0,
        DCBB_MODE_STOP    = 3'h1,
        DCBB_MODE_RESTART = 3'h2,
        DCBB_MODE_SLEEP   = 3'h3,
        DCBB_MODE_FAILSF  = 3'h4
    } dcbb_mode_e;

    typedef enum logic [1:0] {
        DCBB_SS_OFF  = 2'h0,
        DCBB_SS_HOLD = 2'h1,
        DCBB_SS_RUN  = 2'h2
    } dcbb_ss_e;

    typedef struct packed {
        logic [2:0]  mode;
        logic [2:0]  mode_prev;
        logic        first_on;
        logic [1:0]  wk_sync;
        logic [1:0]  oc_sync;
        logic [1:0]  vlow_sync;
        logic [1:0]  vhi_sync;
        logic [1:0]  tgt_sync;
        logic [5:0]  flt_sync;
        logic [7:0]  ctrl;
        logic [2:0]  stat;
        logic        pfm_to_pwm_flag;
        logic        boost_act;
        logic        boost_run;
        logic        auto_pwm;
        logic        smps_en;
        logic        buck_pwm;
        logic        buck_pfm;
        logic [1:0]  ss;
        logic [7:0]  duty;
        logic [3:0]  hold;
        logic [8:0]  per;
        logic        tick;
        logic        event_p;
        logic [7:0]  rdata;
    } dcbb_state_s;

endpackage : dcbb_pkg

// ---- src/dcbb_ctrl.sv ----
// Mode, soft-start and boost control for the cascaded supply
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dcbb_consts.svh"

module dcbb_ctrl (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // System mode from the mode controller
    input  wire logic [2:0] mode_i,
    input  wire logic       stop_cmd_i,
    // Analog comparator inputs (asynchronous)
    input  wire logic       sensed_supply_level_low_i,
    input  wire logic       sensed_supply_level_hyst_i,
    input  wire logic       load_oc_i,
    input  wire logic       out_target_i,
    input  wire logic       sw_open_i,
    input  wire logic       sw_short_i,
    input  wire logic       out_window_i,
    input  wire logic       wake_pin_i,
    // Register port
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // Converter controls
    output logic            smps_en_o,
    output logic            buck_pwm_o,
    output logic            buck_pfm_o,
    output logic      [7:0] buck_duty_o,
    output logic            soft_start_o,
    output logic            boost_run_o,
    output logic            boost_vsel_o,
    output logic            boost_active_flag_o,
    output logic            pfm_to_pwm_event_o
);

    dcbb_pkg::dcbb_state_s s_q;
    dcbb_pkg::dcbb_state_s s_d;
    logic [1:0]            rst_sync_q;
    logic                  rst_n;

    // Reset copy lives outside the struct: it has a reset of its own
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////
    // Mode decoding helpers
    function automatic logic f_supply_on(input logic [2:0] m);
        f_supply_on = (m == dcbb_pkg::DCBB_MODE_NORMAL)
                   || (m == dcbb_pkg::DCBB_MODE_STOP)
                   || (m == dcbb_pkg::DCBB_MODE_RESTART);
    endfunction : f_supply_on

    function automatic logic f_is_off(input logic [2:0] m);
        f_is_off = (m == dcbb_pkg::DCBB_MODE_SLEEP)
                || (m == dcbb_pkg::DCBB_MODE_FAILSF);
    endfunction : f_is_off

    ////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        logic stop_in;
        logic restart_entry;
        logic wk_pwm;
        logic clr_hit;
        stop_in       = 1'b0;
        restart_entry = 1'b0;
        wk_pwm        = 1'b0;
        clr_hit       = 1'b0;
        s_d           = s_q;
        s_d.event_p   = 1'b0;
        s_d.tick      = 1'b0;
        // Synchronisers: only stage one feeds stage two
        s_d.wk_sync   = {s_q.wk_sync[0], wake_pin_i};
        s_d.oc_sync   = {s_q.oc_sync[0], load_oc_i};
        s_d.vlow_sync = {s_q.vlow_sync[0], sensed_supply_level_low_i};
        s_d.vhi_sync  = {s_q.vhi_sync[0], sensed_supply_level_hyst_i};
        s_d.tgt_sync  = {s_q.tgt_sync[0], out_target_i};
        s_d.flt_sync  = {s_q.flt_sync[2:0],
                         out_window_i, sw_short_i, sw_open_i};
        // Mode sample; changes act on the next edge
        s_d.mode      = mode_i;
        s_d.mode_prev = s_q.mode;
        stop_in = (s_q.mode == dcbb_pkg::DCBB_MODE_STOP)
               && (s_q.mode_prev != dcbb_pkg::DCBB_MODE_STOP);
        restart_entry = (s_q.mode == dcbb_pkg::DCBB_MODE_RESTART)
                     && f_is_off(s_q.mode_prev);
        s_d.smps_en = f_supply_on(s_q.mode);

        // Switching period divider gives the soft-start tick
        if (s_q.per == 9'(`DCBB_SW_CYCLES - 1))
        begin
            s_d.per  = 9'h000;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.per = s_q.per + 9'h001;
        end

        // Automatic PFM to PWM in stop; stop command re-arms PFM
        if (s_q.mode != dcbb_pkg::DCBB_MODE_STOP || stop_in)
        begin
            s_d.auto_pwm = 1'b0;
        end
        else if (stop_cmd_i)
        begin
            s_d.auto_pwm = 1'b0;
        end
        else if (s_q.oc_sync[1] && s_q.ctrl[`DCBB_CTRL_PWM_AUTO]
                 && !s_q.auto_pwm)
        begin
            s_d.auto_pwm = 1'b1;
            s_d.event_p  = 1'b1;
        end
        wk_pwm = s_q.ctrl[`DCBB_CTRL_PWM_BY_WK] && s_q.wk_sync[1];

        // Modulation choice; PFM has no frequency of its own
        if (!s_d.smps_en)
        begin
            s_d.buck_pwm = 1'b0;
            s_d.buck_pfm = 1'b0;
        end
        else if (s_q.mode == dcbb_pkg::DCBB_MODE_STOP)
        begin
            s_d.buck_pwm = s_q.auto_pwm || wk_pwm;
            s_d.buck_pfm = !(s_q.auto_pwm || wk_pwm);
        end
        else
        begin
            s_d.buck_pwm = 1'b1;
            s_d.buck_pfm = 1'b0;
        end

        // Soft-start sequencer
        case (s_q.ss)
            dcbb_pkg::DCBB_SS_OFF:
            begin
                s_d.duty = 8'h00;
                if (s_d.smps_en && (s_q.first_on || restart_entry))
                begin
                    s_d.ss       = dcbb_pkg::DCBB_SS_HOLD;
                    s_d.duty     = `DCBB_DUTY_MIN;
                    s_d.hold     = 4'h0;
                    s_d.first_on = 1'b0;
                end
                else if (s_d.smps_en)
                begin
                    s_d.ss = dcbb_pkg::DCBB_SS_RUN;
                end
            end
            dcbb_pkg::DCBB_SS_HOLD:
            begin
                if (!s_d.smps_en)
                begin
                    s_d.ss = dcbb_pkg::DCBB_SS_OFF;
                end
                else if (s_q.tgt_sync[1])
                begin
                    s_d.ss = dcbb_pkg::DCBB_SS_RUN;
                end
                else if (s_q.tick)
                begin
                    if (s_q.hold == `DCBB_HOLD_PERIODS - 4'h1)
                    begin
                        s_d.hold = 4'h0;
                        if (s_q.duty <= `DCBB_DUTY_FULL - `DCBB_DUTY_STEP)
                        begin
                            s_d.duty = s_q.duty + `DCBB_DUTY_STEP;
                        end
                    end
                    else
                    begin
                        s_d.hold = s_q.hold + 4'h1;
                    end
                end
            end
            dcbb_pkg::DCBB_SS_RUN:
            begin
                // Regulation may drive full on-time at low input
                s_d.duty = `DCBB_DUTY_FULL;
                if (!s_d.smps_en)
                begin
                    s_d.ss = dcbb_pkg::DCBB_SS_OFF;
                end
            end
            default:
            begin
                s_d.ss = dcbb_pkg::DCBB_SS_OFF;
            end
        endcase

        // Boost: hysteretic on/off, fixed PWM only
        if (s_q.ctrl[`DCBB_CTRL_BOOST_EN]
            && (s_q.mode == dcbb_pkg::DCBB_MODE_NORMAL
                || s_q.mode == dcbb_pkg::DCBB_MODE_STOP))
        begin
            // Comparators are already set by select bit
            if (s_q.vlow_sync[1])
            begin
                s_d.boost_run = 1'b1;
            end
            else if (s_q.vhi_sync[1])
            begin
                s_d.boost_run = 1'b0;
            end
        end
        else
        begin
            s_d.boost_run = 1'b0;
        end

        // Register writes; faults only record, never steer modes
        clr_hit = wr_i && (addr_i == `DCBB_ADDR_STAT);
        if (wr_i && addr_i == `DCBB_ADDR_CTRL)
            s_d.ctrl = wdata_i;
        s_d.stat = s_q.stat & ~(clr_hit ? wdata_i[2:0] : 3'h0);
        s_d.stat = s_d.stat | s_q.flt_sync[5:3];
        if (wr_i && addr_i == `DCBB_ADDR_WAKE && wdata_i[0])
            s_d.pfm_to_pwm_flag = 1'b0;
        // Set comes after clear so a new event is never lost
        if (s_d.event_p)
            s_d.pfm_to_pwm_flag = 1'b1;
        if (wr_i && addr_i == `DCBB_ADDR_WAKE && wdata_i[1]
            && !s_q.vlow_sync[1])
            s_d.boost_act = 1'b0;
        if (s_d.boost_run && !s_q.boost_run)
            s_d.boost_act = 1'b1;

        // Read data in the cycle after the strobe
        s_d.rdata = 8'h00;
        if (rd_i)
        begin
            if (addr_i == `DCBB_ADDR_CTRL)
                s_d.rdata = s_q.ctrl;
            else if (addr_i == `DCBB_ADDR_STAT)
                s_d.rdata = {5'h00, s_q.stat};
            else if (addr_i == `DCBB_ADDR_WAKE)
                s_d.rdata = {6'h00, s_q.boost_act, s_q.pfm_to_pwm_flag};
            else if (addr_i == `DCBB_ADDR_STATE)
                s_d.rdata = {s_q.mode, s_q.ss, s_q.boost_run,
                             s_q.buck_pwm, s_q.buck_pfm};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register; faults pass two sync flops before the status
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '{mode:      dcbb_pkg::DCBB_MODE_SLEEP,
                     mode_prev: dcbb_pkg::DCBB_MODE_SLEEP,
                     first_on:  1'b1,
                     ctrl:      `DCBB_CTRL_RESET,
                     default:   '0};
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign rdata_o             = s_q.rdata;
    assign smps_en_o           = s_q.smps_en;
    assign buck_pwm_o          = s_q.buck_pwm;
    assign buck_pfm_o          = s_q.buck_pfm;
    assign buck_duty_o         = s_q.duty;
    assign soft_start_o        = s_q.ss[0]; // Only the hold code has bit 0
    assign boost_run_o         = s_q.boost_run;
    assign boost_vsel_o        = s_q.ctrl[`DCBB_CTRL_BOOST_V];
    assign boost_active_flag_o = s_q.boost_act;
    assign pfm_to_pwm_event_o  = s_q.event_p;

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_stop_entry;
        s_q.mode == dcbb_pkg::DCBB_MODE_STOP
            && s_q.mode_prev != dcbb_pkg::DCBB_MODE_STOP;
    endsequence

    property p_off_modes;
        @(posedge clk_i) disable iff (!rst_n)
        f_is_off(s_q.mode) |=> !smps_en_o && !buck_pwm_o && !boost_run_o;
    endproperty
    a_off_modes: assert property (p_off_modes)
        else $error("supply on in sleep or fail-safe");

    property p_pwm_normal;
        @(posedge clk_i) disable iff (!rst_n)
        s_q.mode == dcbb_pkg::DCBB_MODE_NORMAL |=> buck_pwm_o;
    endproperty
    a_pwm_normal: assert property (p_pwm_normal)
        else $error("buck not PWM in normal");

    property p_stop_pfm;
        @(posedge clk_i) disable iff (!rst_n)
        s_stop_entry ##1 (s_q.mode == dcbb_pkg::DCBB_MODE_STOP
                          && !s_q.ctrl[`DCBB_CTRL_PWM_BY_WK])
        |=> buck_pfm_o;
    endproperty
    a_stop_pfm: assert property (p_stop_pfm)
        else $error("buck not PFM after stop entry");

    property p_ss_start;
        @(posedge clk_i) disable iff (!rst_n)
        $rose(soft_start_o) |-> buck_duty_o == `DCBB_DUTY_MIN;
    endproperty
    a_ss_start: assert property (p_ss_start)
        else $error("soft-start not at minimum duty");

    property p_ss_step;
        @(posedge clk_i) disable iff (!rst_n)
        soft_start_o && $changed(buck_duty_o) |->
            buck_duty_o == $past(buck_duty_o) + `DCBB_DUTY_STEP;
    endproperty
    a_ss_step: assert property (p_ss_step)
        else $error("soft-start step wrong");

    property p_auto_event;
        @(posedge clk_i) disable iff (!rst_n)
        pfm_to_pwm_event_o |=> s_q.pfm_to_pwm_flag;
    endproperty
    a_auto_event: assert property (p_auto_event)
        else $error("transition flag not set");

    property p_boost_mode;
        @(posedge clk_i) disable iff (!rst_n)
        boost_run_o |-> $past(s_q.mode == dcbb_pkg::DCBB_MODE_NORMAL
                            || s_q.mode == dcbb_pkg::DCBB_MODE_STOP);
    endproperty
    a_boost_mode: assert property (p_boost_mode)
        else $error("boost running outside normal or stop");

    property p_act_set;
        @(posedge clk_i) disable iff (!rst_n)
        $rose(boost_run_o) |=> boost_active_flag_o;
    endproperty
    a_act_set: assert property (p_act_set)
        else $error("boost active flag not set");

    property p_stat_no_mode;
        @(posedge clk_i) disable iff (!rst_n)
        $rose(s_q.stat[0]) |-> s_q.ctrl == $past(s_q.ctrl);
    endproperty
    a_stat_no_mode: assert property (p_stat_no_mode)
        else $error("status flag changed configuration");

endmodule : dcbb_ctrl
`default_nettype wire

// ---- tb/dcbb_mode_model.sv ----
// Behavioural system mode controller facing the supply control block
`timescale 1ns/1ps
`default_nettype none

module dcbb_mode_model (
    // Clock
    input  wire logic       clk_i,
    // Mode level and stop command towards the block
    output logic      [2:0] mode_o,
    output logic            stop_cmd_o
);
    // Starts in sleep, matching the block's own reset mode
    logic [2:0] mode_q = dcbb_pkg::DCBB_MODE_SLEEP;
    logic       stop_q = 1'b0;

    assign mode_o     = mode_q;
    assign stop_cmd_o = stop_q;

    // Mode is a level launched after an edge and held until the next change
    task automatic go(input logic [2:0] m);
        @(posedge clk_i);
        mode_q <= m;
    endtask : go

    // Rewritten stop command; sent only while stop is already the mode
    task automatic stop_cmd();
        @(posedge clk_i);
        if (mode_q == dcbb_pkg::DCBB_MODE_STOP)
        begin
            stop_q <= 1'b1;
            @(posedge clk_i);
            stop_q <= 1'b0;
        end
    endtask : stop_cmd
endmodule : dcbb_mode_model
`default_nettype wire

// ---- tb/dcbb_ctrl_tb.sv ----
// Self-checking bench for the buck/boost supply control block
`timescale 1ns/1ps
`default_nettype none
`include "dcbb_consts.svh"

module dcbb_ctrl_tb;
    // Bench signals
    logic       clk, rst_n, lo, hy, oc, tgt, sop, ssh, win, wk;
    logic       wr, rd, en, pwm, pfm, ss, brun, bact, ev, stop, vsel;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, duty, q;
    logic [2:0] mode;
    int         num_errors = 0;
    int         total_checks = 0;
    int         ev_cnt = 0;
    int         hold = `DCBB_HOLD_PERIODS * `DCBB_SW_CYCLES;

    ////////////////////////////////////////////////////////////////////////
    // Clock, far side and block
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    dcbb_mode_model pm_u (.clk_i(clk), .mode_o(mode), .stop_cmd_o(stop));

    dcbb_ctrl dut_u (
        .clk_i(clk), .rst_n_i(rst_n), .mode_i(mode), .stop_cmd_i(stop),
        .sensed_supply_level_low_i(lo), .sensed_supply_level_hyst_i(hy), .load_oc_i(oc),
        .out_target_i(tgt), .sw_open_i(sop), .sw_short_i(ssh),
        .out_window_i(win), .wake_pin_i(wk), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .smps_en_o(en), .buck_pwm_o(pwm), .buck_pfm_o(pfm),
        .buck_duty_o(duty), .soft_start_o(ss), .boost_run_o(brun),
        .boost_vsel_o(vsel),
        .boost_active_flag_o(bact), .pfm_to_pwm_event_o(ev)
    );

    // Counting pulses shows a level stuck high as well as a missing event
    always @(posedge clk)
        if (ev === 1'b1) ev_cnt <= ev_cnt + 1;

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input string n, input logic [7:0] s,
                       input logic [7:0] e);
        total_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wreg

    // Read data stand only in the cycle after the strobe
    task automatic rreg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rreg

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // Cuts a hang short well beyond the expected run of some 18 us
    initial
    begin
        #100000;
        num_errors++;
        $display("watchdog expired");
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////
    // Tests
    initial
    begin
        {rst_n, lo, hy, oc, tgt, sop, ssh, win, wk, wr, rd} = 11'h0;
        addr  = 4'h0;
        wdata = 8'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        cyc(4);
        rreg(`DCBB_ADDR_CTRL, q);
        chk("ctrl reset", q, `DCBB_CTRL_RESET);
        wreg(4'hF, 8'hFF);
        rreg(4'hF, q);
        chk("unmapped", q, 8'h00);
        chk("en in sleep", {7'h0, en}, 8'h00);
        chk("vsel reset", {7'h0, vsel}, 8'h00);
        $display("test reset done");

        // Power-up soft-start from sleep into restart, checked at boundaries
        pm_u.go(dcbb_pkg::DCBB_MODE_RESTART);
        cyc(100);
        chk("ss on", {7'h0, ss}, 8'h01);
        chk("duty min", duty, `DCBB_DUTY_MIN);
        cyc(hold - 200);
        chk("duty hold", duty, `DCBB_DUTY_MIN);
        cyc(400);
        chk("duty step", duty, `DCBB_DUTY_MIN + `DCBB_DUTY_STEP);
        @(posedge clk);
        tgt <= 1'b1;
        cyc(8);
        chk("ss off", {7'h0, ss}, 8'h00);
        chk("duty full", duty, `DCBB_DUTY_FULL);
        $display("test soft start done");

        // Every mode: enable and modulation at the ports and in state
        for (int m = 0; m < 5; m++)
        begin
            pm_u.go(3'(m));
            cyc(6);
            chk("smps en", {7'h0, en}, {7'h0, m < 3});
            chk("buck pwm", {7'h0, pwm}, {7'h0, m == 0 || m == 2});
            chk("buck pfm", {7'h0, pfm}, {7'h0, m == 1});
            rreg(`DCBB_ADDR_STATE, q);
            chk("state", q & 8'hE3,
                {3'(m), 3'h0, 1'(m == 0 || m == 2), 1'(m == 1)});
        end
        @(posedge clk);
        tgt <= 1'b0;
        pm_u.go(dcbb_pkg::DCBB_MODE_RESTART);
        cyc(20);
        chk("ss fs restart", {7'h0, ss}, 8'h01);
        chk("duty fs restart", duty, `DCBB_DUTY_MIN);
        @(posedge clk);
        tgt <= 1'b1;
        pm_u.go(dcbb_pkg::DCBB_MODE_NORMAL);
        $display("test modes done");

        // Boost hysteresis, active flag and mode gating
        wreg(`DCBB_ADDR_CTRL, 8'h07);
        rreg(`DCBB_ADDR_CTRL, q);
        chk("ctrl", q, 8'h07);
        chk("vsel lower pair", {7'h0, vsel}, 8'h01);
        @(posedge clk);
        lo <= 1'b1;
        cyc(6);
        chk("boost run", {7'h0, brun}, 8'h01);
        chk("boost act", {7'h0, bact}, 8'h01);
        wreg(`DCBB_ADDR_WAKE, 8'h02);
        cyc(2);
        chk("act kept low", {7'h0, bact}, 8'h01);
        @(posedge clk);
        lo <= 1'b0;
        cyc(6);
        chk("run in hyst", {7'h0, brun}, 8'h01);
        @(posedge clk);
        hy <= 1'b1;
        cyc(6);
        chk("run off", {7'h0, brun}, 8'h00);
        chk("act held", {7'h0, bact}, 8'h01);
        wreg(`DCBB_ADDR_WAKE, 8'h02);
        cyc(2);
        chk("act clear", {7'h0, bact}, 8'h00);
        @(posedge clk);
        lo <= 1'b1;
        hy <= 1'b0;
        pm_u.go(dcbb_pkg::DCBB_MODE_SLEEP);
        cyc(6);
        chk("boost sleep", {7'h0, brun}, 8'h00);
        pm_u.go(dcbb_pkg::DCBB_MODE_NORMAL);
        pm_u.go(dcbb_pkg::DCBB_MODE_STOP);
        cyc(6);
        chk("boost stop", {7'h0, brun}, 8'h01);
        @(posedge clk);
        lo <= 1'b0;
        hy <= 1'b1;
        $display("test boost done");

        // Automatic and manual PFM to PWM in stop
        @(posedge clk);
        oc <= 1'b1;
        cyc(8);
        chk("auto pwm", {7'h0, pwm}, 8'h01);
        chk("pulse count", ev_cnt[7:0], 8'h01);
        rreg(`DCBB_ADDR_WAKE, q);
        chk("pfm flag", q & 8'h01, 8'h01);
        @(posedge clk);
        oc <= 1'b0;
        cyc(6);
        chk("pwm kept", {7'h0, pwm}, 8'h01);
        pm_u.stop_cmd();
        cyc(6);
        chk("pfm back", {7'h0, pfm}, 8'h01);
        wreg(`DCBB_ADDR_CTRL, 8'h03);
        @(posedge clk);
        oc <= 1'b1;
        cyc(8);
        chk("auto off", {7'h0, pfm}, 8'h01);
        chk("no pulse", ev_cnt[7:0], 8'h01);
        @(posedge clk);
        oc <= 1'b0;
        wreg(`DCBB_ADDR_CTRL, 8'h0B);
        @(posedge clk);
        wk <= 1'b1;
        cyc(6);
        chk("wake pwm", {7'h0, pwm}, 8'h01);
        @(posedge clk);
        wk <= 1'b0;
        cyc(6);
        chk("wake pfm", {7'h0, pfm}, 8'h01);
        $display("test switch-over done");

        // Faults are only recorded; a fault still present wins over clear
        @(posedge clk);
        sop <= 1'b1;
        ssh <= 1'b1;
        win <= 1'b1;
        cyc(6);
        rreg(`DCBB_ADDR_STAT, q);
        chk("status set", q, 8'h07);
        chk("en kept", {7'h0, en}, 8'h01);
        chk("pfm kept", {7'h0, pfm}, 8'h01);
        rreg(`DCBB_ADDR_CTRL, q);
        chk("ctrl kept", q, 8'h0B);
        @(posedge clk);
        sop <= 1'b0;
        win <= 1'b0;
        cyc(6);
        wreg(`DCBB_ADDR_STAT, 8'h07);
        rreg(`DCBB_ADDR_STAT, q);
        chk("status w1c", q, 8'h02);
        cyc(1);
        chk("rdata idle", rdata, 8'h00);
        $display("test status done");
        summarize();
    end
endmodule : dcbb_ctrl_tb
`default_nettype wire
